// ---- core/smce_engine.sv ----
/*
 serial monitor command engine: decodes host command bytes and runs them
 against a data register, an address register and target memory.
 assumes a receiver giving one-cycle byte strobes, a transmitter with a
 valid/ready handshake, and memory that acks a held request.
*/
// Notes on behaviour
// R1 - code 00h sets the escape flag, bit 0 of the mode register
// R2 - escape flag clears as soon as the escaped byte is taken
// R3 - code 04h loads memory byte into data low byte, address unchanged
// R4 - code 05h loads memory word into data low 16 bits, address unchanged
// R5 - code 07h stores data low byte at address, data unchanged
// R6 - after the 07h store the address advances by one
// R7 - code 02h sends data low byte, shifts data right eight, address plus one
// R8 - while escaped, the next byte is data even if it looks like a command
// R9 - a 32-bit data register links host and monitor
// R10 - a 24-bit address register points every memory access
`timescale 1ns/100ps
`include "smce_params.svh"

module smce_engine
	import smce_pkg::*;
(
	input  wire logic                    core_clk,
	input  wire logic                    rst,
	input  wire smce_pkg::smce_rx_t      rx,
	output logic                         rx_ready,
	output logic                         tx_valid,
	output logic [7:0]                   tx_data,
	input  wire logic                    tx_ready,
	output smce_pkg::smce_mem_req_t      mem_req,
	input  wire smce_pkg::smce_mem_rsp_t mem_rsp,
	output logic [31:0]                  data_reg,
	output logic [23:0]                  addr_reg,
	output logic                         data_escape_flag
);

	smce_state_t state_q;
	smce_state_t state_d;
	logic [7:0]  mode_q;
	logic [7:0]  mode_d;
	logic [31:0] data_q;
	logic [31:0] data_d;
	logic [23:0] addr_q;
	logic [23:0] addr_d;
	logic [7:0]  cmd_q;
	logic [7:0]  cmd_d;
	logic        mem_start;
	logic        mem_done;
	logic        rx_take;

	////////////////////////////////////////////////////////////////////////
	// command decode and sequencing

	assign rx_take = rx.valid && (state_q == ST_IDLE);

	always_comb begin
		state_d   = state_q;
		mode_d    = mode_q;
		data_d    = data_q;
		addr_d    = addr_q;
		cmd_d     = cmd_q;
		mem_start = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (rx_take && mode_q[`SMCE_ESC_BIT]) begin
					// escaped byte shifts in from the low end, whatever its value
					data_d                 = {data_q[23:0], rx.data}; // [R8] [R9]
					mode_d[`SMCE_ESC_BIT]  = 1'b0;                    // [R2]
				end else if (rx_take) begin
					case (rx.data)
						`SMCE_CMD_ESCAPE: begin
							mode_d[`SMCE_ESC_BIT] = 1'b1; // [R1]
						end
						`SMCE_CMD_TRANSMIT: begin
							state_d = ST_TX;
						end
						`SMCE_CMD_RD_BYTE, `SMCE_CMD_RD_WORD, `SMCE_CMD_WR_BYTE: begin
							cmd_d     = rx.data;
							mem_start = 1'b1;
							state_d   = ST_MEM;
						end
						// unknown codes are swallowed so the host can resync
						default: begin
							state_d = ST_IDLE;
						end
					endcase
				end
			end
			ST_MEM: begin
				if (mem_done) begin
					state_d = ST_IDLE;
					case (cmd_q)
						`SMCE_CMD_RD_BYTE: begin
							data_d = {data_q[31:8], mem_rsp.rdata[7:0]}; // [R3]
						end
						`SMCE_CMD_RD_WORD: begin
							data_d = {data_q[31:16], mem_rsp.rdata}; // [R4]
						end
						`SMCE_CMD_WR_BYTE: begin
							addr_d = addr_q + 24'h00_0001; // [R6]
						end
						default: begin
							data_d = data_q;
						end
					endcase
				end
			end
			ST_TX: begin
				if (tx_ready) begin
					data_d  = {8'h00, data_q[31:8]};  // [R7]
					addr_d  = addr_q + 24'h00_0001;   // [R7]
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			mode_q  <= `SMCE_MODE_RST;
			data_q  <= `SMCE_DATA_RST;
			addr_q  <= `SMCE_ADDR_RST;
			cmd_q   <= 8'h00;
		end else begin
			state_q <= state_d;
			mode_q  <= mode_d;
			data_q  <= data_d;
			addr_q  <= addr_d;
			cmd_q   <= cmd_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// memory access; address is sampled at start so it cannot drift

	smce_mem_port u_mem (
		.core_clk (core_clk),
		.rst      (rst),
		.start    (mem_start),
		.we       (rx.data == `SMCE_CMD_WR_BYTE),
		.word     (rx.data == `SMCE_CMD_RD_WORD),
		.addr     (addr_q),        // [R10]
		.wdata    (data_q[7:0]),   // [R5]
		.mem_req  (mem_req),
		.mem_rsp  (mem_rsp),
		.done     (mem_done)
	);

	assign rx_ready         = (state_q == ST_IDLE);
	assign tx_valid         = (state_q == ST_TX);
	assign tx_data          = data_q[7:0];
	assign data_reg         = data_q;
	assign addr_reg         = addr_q;
	assign data_escape_flag = mode_q[`SMCE_ESC_BIT];

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	esc_set_a: assert property ( // [R1]
		rx_take && !data_escape_flag && rx.data == `SMCE_CMD_ESCAPE
		|=> data_escape_flag && state_q == ST_IDLE && $stable(data_reg))
		else $error("escape command did not set the flag");

	esc_clear_a: assert property ( // [R2]
		rx_take && data_escape_flag |=> !data_escape_flag)
		else $error("escape flag not cleared after data byte");

	esc_data_a: assert property ( // [R8]
		rx_take && data_escape_flag
		|=> state_q == ST_IDLE && data_reg == {$past(data_reg[23:0]), $past(rx.data)})
		else $error("escaped byte not loaded as data");

	rd_byte_a: assert property ( // [R3]
		state_q == ST_MEM && mem_done && cmd_q == `SMCE_CMD_RD_BYTE
		|=> data_reg[7:0] == $past(mem_rsp.rdata[7:0]) && $stable(addr_reg)
			&& data_reg[31:8] == $past(data_reg[31:8]))
		else $error("byte read result wrong");

	rd_word_a: assert property ( // [R4]
		state_q == ST_MEM && mem_done && cmd_q == `SMCE_CMD_RD_WORD
		|=> data_reg[15:0] == $past(mem_rsp.rdata) && $stable(addr_reg))
		else $error("word read result wrong");

	wr_req_a: assert property ( // [R5]
		rx_take && !data_escape_flag && rx.data == `SMCE_CMD_WR_BYTE
		|=> mem_req.req && mem_req.we && mem_req.wdata == $past(data_reg[7:0])
			&& mem_req.addr == $past(addr_reg) && $stable(data_reg))
		else $error("byte write request wrong");

	rd_req_a: assert property ( // [R10]
		rx_take && !data_escape_flag
			&& (rx.data == `SMCE_CMD_RD_BYTE || rx.data == `SMCE_CMD_RD_WORD)
		|=> mem_req.req && !mem_req.we && mem_req.addr == $past(addr_reg)
			&& mem_req.word == ($past(rx.data) == `SMCE_CMD_RD_WORD))
		else $error("read request wrong");

	wr_addr_a: assert property ( // [R6]
		state_q == ST_MEM && mem_done && cmd_q == `SMCE_CMD_WR_BYTE
		|=> addr_reg == $past(addr_reg) + 24'h00_0001 && $stable(data_reg))
		else $error("address not advanced after write");

	tx_shift_a: assert property ( // [R7]
		tx_valid && tx_ready
		|=> data_reg == {8'h00, $past(data_reg[31:8])}
			&& addr_reg == $past(addr_reg) + 24'h00_0001 && !tx_valid)
		else $error("transmit did not shift and advance");

	tx_start_a: assert property ( // [R7]
		rx_take && !data_escape_flag && rx.data == `SMCE_CMD_TRANSMIT
		|=> tx_valid && tx_data == $past(data_reg[7:0]))
		else $error("transmit not offered");

	idle_hold_a: assert property ( // [R10]
		state_q == ST_IDLE && !rx.valid |=> $stable(addr_reg) && $stable(data_reg))
		else $error("registers changed without a command");

endmodule

// ---- core/smce_mem_port.sv ----
/*
 memory request holder: latches one access on start, holds it until the
 memory acknowledges. assumes memory answers with ack and read data in
 the same cycle, while req is high.
*/
`timescale 1ns/100ps

module smce_mem_port
	import smce_pkg::*;
(
	input  wire logic                    core_clk,
	input  wire logic                    rst,
	input  wire logic                    start,
	input  wire logic                    we,
	input  wire logic                    word,
	input  wire logic [23:0]             addr,
	input  wire logic [7:0]              wdata,
	output smce_pkg::smce_mem_req_t      mem_req,
	input  wire smce_pkg::smce_mem_rsp_t mem_rsp,
	output logic                         done
);

	smce_mem_req_t req_q;
	smce_mem_req_t req_d;

	always_comb begin
		req_d = req_q;
		if (start) begin
			req_d = '{req: 1'b1, we: we, word: word, addr: addr, wdata: wdata};
		end else if (req_q.req && mem_rsp.ack) begin
			req_d.req = 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			req_q <= '0;
		end else begin
			req_q <= req_d;
		end
	end

	assign mem_req = req_q;
	assign done    = req_q.req & mem_rsp.ack;

endmodule

// ---- core/smce_params.svh ----
/*
 constants of the serial monitor command engine: command codes, field
 positions and reset values. assumes inclusion by bare name.
*/
`ifndef SMCE_PARAMS_SVH
`define SMCE_PARAMS_SVH

`define SMCE_CMD_ESCAPE   8'h00
`define SMCE_CMD_TRANSMIT 8'h02
`define SMCE_CMD_RD_BYTE  8'h04
`define SMCE_CMD_RD_WORD  8'h05
`define SMCE_CMD_WR_BYTE  8'h07

`define SMCE_ESC_BIT      0
`define SMCE_MODE_RST     8'h00
`define SMCE_DATA_RST     32'h0000_0000
`define SMCE_ADDR_RST     24'h00_0000

`endif

// ---- core/smce_pkg.sv ----
/*
 types shared by the command engine and its memory port.
 assumes smce_params.svh on the include path.
*/
package smce_pkg;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} smce_rx_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic        word;
		logic [23:0] addr;
		logic [7:0]  wdata;
	} smce_mem_req_t;

	typedef struct packed {
		logic        ack;
		logic [15:0] rdata;
	} smce_mem_rsp_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_MEM,
		ST_TX
	} smce_state_t;

endpackage

// ---- verification/smce_mem_model.sv ----
/*
 target memory behind the engine: 256 bytes, preloaded with i ^ 5a.
 assumes one held request at a time; slow adds one wait cycle.
*/
`timescale 1ns/100ps

module smce_mem_model (
	input  wire logic                    core_clk,
	input  wire logic                    rst,
	input  wire logic                    slow,
	input  wire smce_pkg::smce_mem_req_t mem_req,
	output smce_pkg::smce_mem_rsp_t      mem_rsp
);
	import smce_pkg::*;
	logic [7:0] mem [256];
	logic       wait_q;
	logic [7:0] a;
	assign a = mem_req.addr[7:0];
	assign mem_rsp.ack = mem_req.req & (~slow | wait_q);
	// read data is junk outside the ack cycle, never the last value
	assign mem_rsp.rdata = mem_rsp.ack ? {mem[a + 8'h01], mem[a]}
		: ~{mem[a + 8'h01], mem[a]};
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
	end
	always @(posedge core_clk or posedge rst) begin
		if (rst) wait_q <= 1'b0;
		else wait_q <= mem_req.req & ~mem_rsp.ack;
	end
	always @(posedge core_clk) begin
		if (mem_rsp.ack & mem_req.we) mem[a] <= mem_req.wdata;
	end
endmodule

// ---- verification/testbench.sv ----
/*
 bench for smce_engine: escaped loads, store, send and reads.
 assumes smce_mem_model as the memory, driven fast or slow.
*/
`timescale 1ns/100ps

module testbench;
	import smce_pkg::*;
	logic          core_clk;
	logic          rst;
	logic          tx_ready;
	logic          slow;
	smce_rx_t      rx;
	logic          rx_ready;
	logic          tx_valid;
	logic [7:0]    tx_data;
	smce_mem_req_t mem_req;
	smce_mem_rsp_t mem_rsp;
	logic [31:0]   data_reg;
	logic [23:0]   addr_reg;
	logic          data_escape_flag;
	int            failures = 0;
	int            comparisons = 0;

	smce_engine smce_engine_inst (.core_clk(core_clk), .rst(rst), .rx(rx),
		.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .mem_req(mem_req), .mem_rsp(mem_rsp),
		.data_reg(data_reg), .addr_reg(addr_reg),
		.data_escape_flag(data_escape_flag));
	smce_mem_model smce_mem_model_inst (.core_clk(core_clk), .rst(rst),
		.slow(slow), .mem_req(mem_req), .mem_rsp(mem_rsp));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic end_sim();
		if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask

	// bounded wait for the engine, then a one-cycle byte strobe
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 50 && rx_ready !== 1'b1; i++) tick();
		if (rx_ready !== 1'b1) begin
			failures++;
			end_sim();
		end else begin
			rx.valid = 1'b1;
			rx.data = b;
			tick();
			rx.valid = 1'b0;
			tick();
		end
	endtask

	task automatic t_load(input logic [31:0] w);
		for (int i = 3; i >= 0; i--) begin
			send(8'h00);
			check("flag set", data_escape_flag, 1'b1);
			send(w[8*i+:8]);
			check("flag clear", data_escape_flag, 1'b0);
			check("no send", tx_valid, 1'b0);
		end
		check("data", data_reg, w);
	endtask

	task automatic t_store();
		send(8'h07);
		send(8'h01);
		check("mem", smce_mem_model_inst.mem[0], 8'h80);
		check("data kept", data_reg, 32'h2e11_0280);
		check("addr", addr_reg, 24'h00_0001);
	endtask

	task automatic t_send();
		send(8'h02);
		check("tx byte", tx_data, 8'h80);
		repeat (3) tick();
		check("tx held", tx_valid, 1'b1);
		check("busy", rx_ready, 1'b0);
		tx_ready = 1'b1;
		tick();
		tx_ready = 1'b0;
		check("tx done", tx_valid, 1'b0);
		check("ready", rx_ready, 1'b1);
		check("shifted", data_reg, 32'h002e_1102);
		check("addr", addr_reg, 24'h00_0002);
	endtask

	task automatic t_reads();
		slow = 1'b1;
		send(8'h04);
		send(8'h01);
		check("byte rd", data_reg, 32'h002e_1158);
		check("addr", addr_reg, 24'h00_0002);
		slow = 1'b0;
		send(8'h05);
		send(8'h01);
		check("word rd", data_reg, 32'h002e_5958);
		check("addr", addr_reg, 24'h00_0002);
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		tx_ready = 1'b0;
		slow = 1'b0;
		rx = '0;
		repeat (16) @(posedge core_clk);
		#1;
		rst = 1'b0;
		check("data rst", data_reg, 32'h0000_0000);
		check("addr rst", addr_reg, 24'h00_0000);
		check("flag rst", data_escape_flag, 1'b0);
		// 02 as the third byte must load, not send
		t_load(32'h2e11_0280);
		t_store();
		t_send();
		t_reads();
		end_sim();
	end
endmodule
